// ==== hw/cmp_channel.sv ====
// One comparator channel: input selection and output paths
`timescale 1ns/1ps
module cmp_channel
  import cmp_mux_pkg::*;
#(
  parameter int PINS = PIN_COUNT
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] route,
  output logic [PINS-1:0] pos_pin_sel,
  output logic [PINS-1:0] neg_pin_sel,
  input wire logic compare_result,
  output logic raw_out,
  output logic latched_out
);
  if (PINS != PIN_COUNT) begin : g_pins_check
    $error("cmp_channel supports exactly twelve pin pairs");
  end

  logic sync1_reg;
  logic sync2_reg;

  function automatic logic [PINS-1:0] decode_sel(input logic [3:0] code);
    logic [PINS-1:0] onehot;
    onehot = '0;
    if (code <= LAST_PIN_CODE) begin
      onehot[code] = 1'b1;
    end
    return onehot;
  endfunction

  // Negative input select from route[7:4], positive from route[3:0]
  assign neg_pin_sel = decode_sel(route[NEG_MSB:NEG_LSB]);
  assign pos_pin_sel = decode_sel(route[POS_MSB:POS_LSB]);

  // Raw path needs no clock
  assign raw_out = compare_result;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= compare_result;
      sync2_reg <= sync1_reg;
    end
  end

  assign latched_out = sync2_reg;

  latched_sync_a: assert property (@(posedge clk) disable iff (!resetn)
    $past(resetn) && $past(resetn, SYNC_STAGES) |->
    latched_out == $past(compare_result, SYNC_STAGES))
    else $error("latched output not two cycles behind compare");
endmodule

// ==== hw/cmp_route_ctrl.sv ====
// Comparator input routing registers and output pin control
`timescale 1ns/1ps
module cmp_route_ctrl
  import cmp_mux_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_page,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  input wire logic cmp0_result,
  input wire logic cmp1_result,
  output logic [PIN_COUNT-1:0] cmp0_pos_pin_sel,
  output logic [PIN_COUNT-1:0] cmp0_neg_pin_sel,
  output logic [PIN_COUNT-1:0] cmp1_pos_pin_sel,
  output logic [PIN_COUNT-1:0] cmp1_neg_pin_sel,
  output logic cmp0_latched_out,
  output logic cmp1_latched_out,
  output logic cmp0_raw_out,
  output logic cmp1_raw_out,
  input wire logic cmp0_reset_enable,
  output logic cmp0_reset_request,
  input wire logic [3:0] out_push_pull,
  input wire logic [3:0] out_pin_enable,
  output logic [3:0] out_pin_o,
  output logic [3:0] out_pin_oe
);
  logic [7:0] comparator0_input_route_reg;
  logic [7:0] comparator1_input_route_reg;
  logic [7:0] rdata_next;
  logic [3:0] out_level;
  logic hit0;
  logic hit1;

  assign hit0 = (sfr_addr == ROUTE0_ADDR) && (sfr_page == ROUTE_PAGE);
  assign hit1 = (sfr_addr == ROUTE1_ADDR) && (sfr_page == ROUTE_PAGE);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      comparator0_input_route_reg <= ROUTE_RESET;
    end else if (sfr_wr && hit0) begin
      comparator0_input_route_reg <= sfr_wdata;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      comparator1_input_route_reg <= ROUTE_RESET;
    end else if (sfr_wr && hit1) begin
      comparator1_input_route_reg <= sfr_wdata;
    end
  end

  always_comb begin
    rdata_next = 8'h00;
    if (hit0) begin
      rdata_next = comparator0_input_route_reg;
    end else if (hit1) begin
      rdata_next = comparator1_input_route_reg;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      sfr_rdata <= rdata_next;
    end
  end

  // Both channels share one implementation
  cmp_channel #(.PINS(PIN_COUNT)) u_cmp0 (
    .clk(clk),
    .resetn(resetn),
    .route(comparator0_input_route_reg),
    .pos_pin_sel(cmp0_pos_pin_sel),
    .neg_pin_sel(cmp0_neg_pin_sel),
    .compare_result(cmp0_result),
    .raw_out(cmp0_raw_out),
    .latched_out(cmp0_latched_out)
  );

  cmp_channel #(.PINS(PIN_COUNT)) u_cmp1 (
    .clk(clk),
    .resetn(resetn),
    .route(comparator1_input_route_reg),
    .pos_pin_sel(cmp1_pos_pin_sel),
    .neg_pin_sel(cmp1_neg_pin_sel),
    .compare_result(cmp1_result),
    .raw_out(cmp1_raw_out),
    .latched_out(cmp1_latched_out)
  );

  // Reset source on comparator 0 only, low result requests reset
  assign cmp0_reset_request = cmp0_reset_enable && !cmp0_latched_out;

  // Pin order: cmp0 latched, cmp0 raw, cmp1 latched, cmp1 raw
  assign out_level = {cmp1_raw_out, cmp1_latched_out,
                      cmp0_raw_out, cmp0_latched_out};

  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_pin
      // Open drain drives low only; push-pull drives both levels
      assign out_pin_o[i] = out_push_pull[i] ? out_level[i] : 1'b0;
      assign out_pin_oe[i] = out_pin_enable[i] &&
                             (out_push_pull[i] || !out_level[i]);
    end
  endgenerate

  route_write_a: assert property (@(posedge clk) disable iff (!resetn)
    (sfr_wr && hit0) |=> comparator0_input_route_reg == $past(sfr_wdata))
    else $error("route 0 write not stored");

  route1_write_a: assert property (@(posedge clk) disable iff (!resetn)
    (sfr_wr && hit1) |=> comparator1_input_route_reg == $past(sfr_wdata))
    else $error("route 1 write not stored");

  neg_none_a: assert property (@(posedge clk) disable iff (!resetn)
    (comparator0_input_route_reg[7:4] > 4'hB) |-> cmp0_neg_pin_sel == '0)
    else $error("negative select drives pin for none code");

  neg_pick_a: assert property (@(posedge clk) disable iff (!resetn)
    (comparator0_input_route_reg[7:4] <= 4'hB) |->
    $onehot(cmp0_neg_pin_sel))
    else $error("negative select not one-hot");

  pos_pick_a: assert property (@(posedge clk) disable iff (!resetn)
    (comparator0_input_route_reg[3:0] <= 4'hB) |->
    cmp0_pos_pin_sel[comparator0_input_route_reg[3:0]])
    else $error("positive select wrong pin");

  raw_follow_a: assert property (@(posedge clk)
    cmp0_raw_out == cmp0_result && cmp1_raw_out == cmp1_result)
    else $error("raw output not following compare");

  reset_src_a: assert property (@(posedge clk) disable iff (!resetn)
    !cmp0_reset_enable |-> !cmp0_reset_request)
    else $error("reset request without enable");

  open_drain_a: assert property (@(posedge clk) disable iff (!resetn)
    (out_pin_oe & ~out_push_pull & out_pin_o) == 4'h0)
    else $error("open drain pin driven high");

  route0_read_a: assert property (@(posedge clk) disable iff (!resetn)
    (sfr_rd && hit0) |=>
    sfr_rdata == $past(comparator0_input_route_reg))
    else $error("route 0 read data wrong");

  route1_read_a: assert property (@(posedge clk) disable iff (!resetn)
    (sfr_rd && hit1) |=>
    sfr_rdata == $past(comparator1_input_route_reg))
    else $error("route 1 read data wrong");

  unmapped_read_a: assert property (@(posedge clk) disable iff (!resetn)
    (sfr_rd && !hit0 && !hit1) |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");

  page_refuse_a: assert property (@(posedge clk) disable iff (!resetn)
    (sfr_wr && sfr_page != ROUTE_PAGE) |=>
    $stable(comparator0_input_route_reg) &&
    $stable(comparator1_input_route_reg))
    else $error("write on other page changed a route");

  neg_pin_a: assert property (@(posedge clk) disable iff (!resetn)
    (comparator0_input_route_reg[NEG_MSB:NEG_LSB] <= LAST_PIN_CODE) |->
    cmp0_neg_pin_sel[comparator0_input_route_reg[NEG_MSB:NEG_LSB]])
    else $error("negative select wrong pin");

  pos_none_a: assert property (@(posedge clk) disable iff (!resetn)
    (comparator0_input_route_reg[POS_MSB:POS_LSB] > LAST_PIN_CODE) |->
    cmp0_pos_pin_sel == '0)
    else $error("positive select drives pin for none code");

  neg1_none_a: assert property (@(posedge clk) disable iff (!resetn)
    (comparator1_input_route_reg[NEG_MSB:NEG_LSB] > LAST_PIN_CODE) |->
    cmp1_neg_pin_sel == '0)
    else $error("comparator 1 negative select drives pin for none code");

  pos1_pick_a: assert property (@(posedge clk) disable iff (!resetn)
    (comparator1_input_route_reg[POS_MSB:POS_LSB] <= LAST_PIN_CODE) |->
    $onehot(cmp1_pos_pin_sel) &&
    cmp1_pos_pin_sel[comparator1_input_route_reg[POS_MSB:POS_LSB]])
    else $error("comparator 1 positive select wrong pin");

  latched0_a: assert property (@(posedge clk) disable iff (!resetn)
    $past(resetn) && $past(resetn, SYNC_STAGES) |->
    cmp0_latched_out == $past(cmp0_result, SYNC_STAGES))
    else $error("comparator 0 latched output delay wrong");

  latched1_a: assert property (@(posedge clk) disable iff (!resetn)
    $past(resetn) && $past(resetn, SYNC_STAGES) |->
    cmp1_latched_out == $past(cmp1_result, SYNC_STAGES))
    else $error("comparator 1 latched output delay wrong");

  reset_req_a: assert property (@(posedge clk) disable iff (!resetn)
    (cmp0_reset_enable && !cmp0_latched_out) |-> cmp0_reset_request)
    else $error("reset request missing");

  pin_enable_a: assert property (@(posedge clk) disable iff (!resetn)
    (out_pin_oe & ~out_pin_enable) == 4'h0)
    else $error("unassigned pin driven");

  pp_drive0_a: assert property (@(posedge clk) disable iff (!resetn)
    (out_pin_enable[0] && out_push_pull[0]) |->
    out_pin_oe[0] && out_pin_o[0] == cmp0_latched_out)
    else $error("push-pull pin 0 not driving latched level");

  pp_drive1_a: assert property (@(posedge clk) disable iff (!resetn)
    (out_pin_enable[2] && out_push_pull[2]) |->
    out_pin_oe[2] && out_pin_o[2] == cmp1_latched_out)
    else $error("push-pull pin 2 not driving latched level");

  od_release0_a: assert property (@(posedge clk) disable iff (!resetn)
    (out_pin_enable[1] && !out_push_pull[1] && cmp0_raw_out) |->
    !out_pin_oe[1])
    else $error("open drain pin 1 not released when high");

  od_release1_a: assert property (@(posedge clk) disable iff (!resetn)
    (out_pin_enable[3] && !out_push_pull[3] && cmp1_raw_out) |->
    !out_pin_oe[3])
    else $error("open drain pin 3 not released when high");
endmodule

// ==== inc/cmp_mux_pkg.sv ====
// Constants for the comparator input routing block
package cmp_mux_pkg;
  localparam int SEL_WIDTH = 4;
  localparam int PIN_COUNT = 12;
  localparam logic [7:0] ROUTE0_ADDR = 8'h9C;
  localparam logic [7:0] ROUTE1_ADDR = 8'h9F;
  localparam logic [7:0] ROUTE_PAGE = 8'h00;
  localparam logic [7:0] ROUTE_RESET = 8'h77;
  localparam int NEG_MSB = 7;
  localparam int NEG_LSB = 4;
  localparam int POS_MSB = 3;
  localparam int POS_LSB = 0;
  localparam logic [3:0] LAST_PIN_CODE = 4'hB;
  localparam int SYNC_STAGES = 2;
endpackage

// ==== sim/sfr_host.sv ====
// Software-side register access model
`timescale 1ns/1ps
module sfr_host (
  input wire logic clk,
  input wire logic [7:0] rdata,
  output logic [7:0] addr,
  output logic [7:0] page,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd
);
  initial begin
    addr = 8'h00;
    page = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end
  // One byte access, strobe held for one edge
  task acc(input logic [7:0] a, pg, dt, input logic we,
    output logic [7:0] q);
    @(posedge clk);
    addr <= a;
    page <= pg;
    wdata <= dt;
    wr <= we;
    rd <= ~we;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    wdata <= ~dt;
    #1;
    q = rdata;
  endtask
endmodule

// ==== sim/tb.sv ====
// Testbench for comparator routing control
`timescale 1ns/1ps
module tb;
  import cmp_mux_pkg::*;
  logic clk = 0, resetn = 0, run = 1, r0 = 0, r1 = 0, ren = 0;
  logic [3:0] pp = 4'h0, pe = 4'h0, po, poe;
  logic [7:0] a, p, d, q, rdat;
  logic w, rd, rq, l0, l1, w0, w1;
  logic [11:0] ps0, ns0, ps1, ns1;
  logic [11:0] analog_neg, analog_pos;
  int miscompares = 0, total_checks = 0;
  always #20 clk = run ? ~clk : clk;
  sfr_host host (.clk(clk), .rdata(rdat), .addr(a), .page(p),
    .wdata(d), .wr(w), .rd(rd));
  cmp_route_ctrl i_cmp_route_ctrl (.clk(clk), .resetn(resetn),
    .sfr_addr(a), .sfr_page(p), .sfr_wdata(d), .sfr_wr(w), .sfr_rd(rd),
    .sfr_rdata(rdat), .cmp0_result(r0), .cmp1_result(r1),
    .cmp0_pos_pin_sel(ps0), .cmp0_neg_pin_sel(ns0),
    .cmp1_pos_pin_sel(ps1), .cmp1_neg_pin_sel(ns1),
    .cmp0_latched_out(l0), .cmp1_latched_out(l1), .cmp0_raw_out(w0),
    .cmp1_raw_out(w1), .cmp0_reset_enable(ren), .cmp0_reset_request(rq),
    .out_push_pull(pp), .out_pin_enable(pe), .out_pin_o(po),
    .out_pin_oe(poe));
  task chk(input string n, input logic [11:0] e, g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  function automatic logic [11:0] hot(input int c);
    return c < PIN_COUNT ? 12'h001 << c : 12'h000;
  endfunction
  task t_reset;
    host.acc(ROUTE0_ADDR, ROUTE_PAGE, 8'h00, 1'b0, q);
    chk("route0", 12'h077, {4'h0, q});
    host.acc(ROUTE1_ADDR, ROUTE_PAGE, 8'h00, 1'b0, q);
    chk("route1", 12'h077, {4'h0, q});
    chk("pos0", 12'h080, ps0);
    chk("neg0", 12'h080, ns0);
    chk("rst off", 12'h000, {11'h0, rq});
    $display("reset test done");
  endtask
  task t_codes;
    for (int c = 0; c < 16; c++) begin
      analog_neg = hot(c);
      analog_pos = hot(15 - c);
      host.acc(ROUTE0_ADDR, ROUTE_PAGE, {c[3:0], 4'hF - c[3:0]}, 1'b1, q);
      host.acc(ROUTE1_ADDR, ROUTE_PAGE, {4'hF - c[3:0], c[3:0]}, 1'b1, q);
      chk("neg0", hot(c), ns0);
      chk("pos0", hot(15 - c), ps0);
      chk("pos1", hot(c), ps1);
      chk("neg1", hot(15 - c), ns1);
      chk("skip", 12'h000, (ns0 & ~analog_neg) | (ps0 & ~analog_pos));
      host.acc(ROUTE1_ADDR, ROUTE_PAGE, 8'h00, 1'b0, q);
      chk("rd1", {4'h0, 4'hF - c[3:0], c[3:0]}, {4'h0, q});
    end
    host.acc(ROUTE0_ADDR, 8'h0C, 8'h00, 1'b1, q);
    host.acc(ROUTE0_ADDR, ROUTE_PAGE, 8'h00, 1'b0, q);
    chk("page", 12'h0F0, {4'h0, q});
    host.acc(8'h9D, ROUTE_PAGE, 8'h00, 1'b0, q);
    chk("unmapped", 12'h000, {4'h0, q});
    $display("code test done");
  endtask
  task t_out;
    pe <= 4'hF;
    pp <= 4'h5;
    ren <= 1'b1;
    for (int v = 1; v >= 0; v--) begin
      @(posedge clk);
      r0 <= v[0];
      r1 <= v[0];
      @(posedge clk);
      #1;
      chk("raw", {10'h0, {2{v[0]}}}, {10'h0, w1, w0});
      chk("early", {10'h0, {2{~v[0]}}}, {10'h0, l1, l0});
      @(posedge clk);
      #1;
      chk("latched", {10'h0, {2{v[0]}}}, {10'h0, l1, l0});
      chk("rst", {11'h0, ~v[0]}, {11'h0, rq});
      chk("o", {8'h0, 1'b0, v[0], 1'b0, v[0]}, {8'h0, po});
      chk("oe", {8'h0, ~v[0], 1'b1, ~v[0], 1'b1}, {8'h0, poe});
    end
    pe <= 4'h0;
    @(posedge clk);
    #1;
    chk("oe off", 12'h000, {8'h0, poe});
    $display("output test done");
  endtask
  task t_stop;
    @(posedge clk);
    run = 0;
    #100;
    r0 <= 1'b1;
    r1 <= 1'b1;
    #10;
    chk("stop raw", 12'h003, {10'h0, w1, w0});
    chk("stop latch", 12'h000, {10'h0, l1, l0});
    run = 1;
    $display("stop test done");
  endtask
  task end_of_test;
    $display("checks %0d bad %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    t_reset;
    t_codes;
    t_out;
    t_stop;
    end_of_test;
  end
  initial begin
    #100000;
    miscompares++;
    end_of_test;
  end
endmodule
